// >>> verilog/pds_consts.svh
// Constants of the power-down sequencer: offsets, field positions, timings
`ifndef PDS_CONSTS_SVH
`define PDS_CONSTS_SVH
`define PDS_NOUT 9
`define PDS_PG 7
`define PDS_RST 8
`define PDS_MCLK_MHZ 50
`define PDS_US_CYC (`PDS_MCLK_MHZ)
`define PDS_SDWN_US 500
`define PDS_TB_US {11'd500, 11'd250, 11'd120, 11'd30}
`define PDS_GAP_US {11'd1000, 11'd500, 11'd250, 11'd120}
`define PDS_LEAD_US {11'd500, 11'd100, 11'd10, 11'd0}
`define PDS_OFF_CTRL 8'h00
`define PDS_OFF_STAT 8'h04
`define PDS_OFF_FCNT 8'h08
`define PDS_OFF_GDLY 8'h0c
`define PDS_OFF_SLOT 8'h10
`define PDS_OFF_STBY 8'h34
`define PDS_C_SWOFF 0
`define PDS_C_PDMODE 1
`define PDS_C_OVEN 2
`define PDS_C_OVSD 3
`define PDS_C_PGPO 4
`define PDS_C_IMASK 5
`define PDS_C_BTN 6
`define PDS_C_TB 8
`define PDS_C_LEAD 10
`define PDS_C_FLIM 12
`define PDS_C_WLIM 16
`define PDS_S_PEND 0
`define PDS_S_SBDONE 1
`define PDS_S_HARD 2
`define PDS_S_ST 4
`define PDS_S_ON 8
`define PDS_WHY_OFF 2'h0
`define PDS_WHY_STBY 2'h1
`define PDS_WHY_HARD 2'h2
`endif

// >>> verilog/pds_pkg.sv
// Types of the power-down sequencer
`include "pds_consts.svh"
package pds_pkg;
    typedef enum logic [2:0] {PDS_OFF, PDS_RUN, PDS_STBY, PDS_PD, PDS_FAILSAFE} pds_fsm_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pds_bus_t;
    typedef struct packed {
        logic power_on_pin;
        logic input_overvoltage_event;
        logic thermal_shutdown;
        logic regulator_fault;
    } pds_pins_t;
    typedef struct packed {
        logic [1:0] stored_slot_timebase;
        logic [`PDS_NOUT-1:0][7:0] stored_slot;
    } pds_otp_t;
    typedef struct packed {
        pds_fsm_t st;
        logic [1:0] why;
        pds_pins_t pin_s1;
        pds_pins_t pin_s2;
        pds_pins_t pin_p;
        logic [5:0] pre;
        logic swoff, pdmode, ovlo_en, ovlo_sd, pgpo, imask, btn_mode;
        logic [1:0] tbase, lead;
        logic [3:0] flim, wlim;
        logic [3:0][1:0] gdly;
        logic [`PDS_NOUT-1:0][7:0] slot;
        logic [`PDS_NOUT-1:0][1:0] grp;
        logic [`PDS_NOUT-1:0] stby;
        logic pend, sbdone, hardf;
        logic [3:0] fcnt, wcnt;
        logic [9:0] swt;
        logic armed;
        logic [15:0] hold, flt;
        logic [`PDS_NOUT-1:0] on, tgt;
        logic [7:0] cur;
        logic [1:0] gi, ph;
        logic [10:0] tmr;
        logic [31:0] rdata;
    } pds_regs_t;
endpackage

// >>> verilog/pds_sequencer.sv
// Turn-off event detection and power-down sequencing
//
// Summary of operation
// R1 - Button mode 0: power-on pin low starts power down.
// R2 - Button mode 1: pin falls and stays low beyond off hold time.
// R3 - Software off write starts 500 us timer, sets pending flag, interrupt.
// R4 - Clearing pending flag cancels; timer expiry starts power down.
// R5 - Software off bit self-clears once pending flag is cleared.
// R6 - Overvoltage event with both enables set starts power down.
// R7 - Fault held until fault timer expires is a hard fault.
// R8 - Fault rising with event count equal to limit is a hard fault.
// R9 - Watchdog fail count reaching its limit is a hard fault.
// R10 - Rising thermal shutdown is a hard fault.
// R11 - Hard fault: finish power down, then fail-safe state.
// R12 - Order mode 0 sequential, 1 grouped.
// R13 - Standby entry runs sequencer only if some output turns off.
// R14 - Standby entry always sets the standby done flag at its end.
// R15 - Sequential: slot 0 outputs off at once, others reverse, one timebase apart.
// R16 - Power-good as output drops at its own slot.
// R17 - Timebase and slots reload from stored values in off state.
// R18 - Group select 00..11 means group 4..1; group members drop together.
// R19 - Groups run 4 toward 1, empty groups skipped.
// R20 - After each group wait its gap delay 120/250/500/1000 us.
// R21 - Reset group regulators drop after reset lead delay.
// R22 - Indicator-mode power-good should be configured into group 1.
// R23 - Timebase select 30/120/250/500 us.
`timescale 1ns/1ns
`default_nettype none
`include "pds_consts.svh"
module pds_sequencer #(
    parameter int OFF_HOLD_US = 1000,
    parameter int FAULT_US = 1000
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire pds_pkg::pds_bus_t bus,
    output logic [31:0] bus_rdata,
    // Asynchronous pins
    input wire pds_pkg::pds_pins_t pins,
    // Same-clock control
    input wire logic pwrup_go,
    input wire logic standby_req,
    input wire logic wd_fail,
    input wire pds_pkg::pds_otp_t otp,
    // Outputs
    output logic [6:0] reg_enable,
    output logic power_good_pin,
    output logic host_reset_out_n,
    output logic interrupt_out_n,
    output logic failsafe
);
    import pds_pkg::*;

    pds_regs_t s_q, s_d;
    logic tick, go_off, go_hard, fall_on, rise_flt, rise_tsd, live, start, sh;
    logic [`PDS_NOUT-1:0] hit, mem, slot0, tnew;
    logic [1:0] wnew;
    logic [3:0] si;

    function automatic logic [4:0] slot_dec(input logic [7:0] a);
        logic [7:0] d;
        d = a - `PDS_OFF_SLOT;
        slot_dec = {(a >= `PDS_OFF_SLOT) && (d[1:0] == 2'h0) && (d[7:2] < 6'(`PDS_NOUT)), d[5:2]};
    endfunction

    function automatic logic [10:0] pick(input logic [1:0] s, input logic [43:0] tbl);
        pick = tbl[11*s +: 11];
    endfunction

    always_comb begin
        s_d = s_q;
        {sh, si} = slot_dec(bus.addr);
        tick = s_q.pre == 6'(`PDS_US_CYC - 1);
        s_d.pre = tick ? 6'h00 : s_q.pre + 6'h01;
        // Only the second stage and its delayed copy feed logic
        s_d.pin_s1 = pins;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.pin_p = s_q.pin_s2;
        fall_on = s_q.pin_p.power_on_pin & ~s_q.pin_s2.power_on_pin;
        rise_flt = ~s_q.pin_p.regulator_fault & s_q.pin_s2.regulator_fault;
        rise_tsd = ~s_q.pin_p.thermal_shutdown & s_q.pin_s2.thermal_shutdown;
        live = (s_q.st == PDS_RUN) || (s_q.st == PDS_STBY);
        for (int i = 0; i < `PDS_NOUT; i++) begin
            slot0[i] = s_q.slot[i] == 8'h00;
            mem[i] = s_q.tgt[i] && (s_q.grp[i] == s_q.gi);
            hit[i] = s_q.tgt[i] && s_q.on[i] && (s_q.slot[i] == s_q.cur);
        end
        go_off = 1'b0;
        go_hard = 1'b0;
        start = 1'b0;
        tnew = '0;
        wnew = `PDS_WHY_OFF;

        // Power-on pin
        if (!s_q.btn_mode) begin
            go_off = ~s_q.pin_s2.power_on_pin; // [R1]
            s_d.armed = 1'b0;
            s_d.hold = 16'h0000;
        end else if (s_q.pin_s2.power_on_pin) begin
            s_d.armed = 1'b0;
            s_d.hold = 16'h0000;
        end else if (fall_on) begin
            s_d.armed = 1'b1;
            s_d.hold = 16'h0000;
        end else if (s_q.armed) begin
            if (s_q.hold > 16'(OFF_HOLD_US)) begin
                go_off = 1'b1; // [R2]
            end else if (tick) begin
                s_d.hold = s_q.hold + 16'h0001;
            end
        end

        // Software off timer
        if (s_q.pend && s_q.swoff) begin
            if (s_q.swt == 10'(`PDS_SDWN_US)) begin
                go_off = 1'b1; // [R4]
            end else if (tick) begin
                s_d.swt = s_q.swt + 10'h001;
            end
        end

        if (s_q.ovlo_en && s_q.ovlo_sd && s_q.pin_s2.input_overvoltage_event) begin
            go_off = 1'b1; // [R6]
        end

        // Hard faults
        if (!s_q.pin_s2.regulator_fault) begin
            s_d.flt = 16'h0000;
        end else if (s_q.flt >= 16'(FAULT_US)) begin
            go_hard = 1'b1; // [R7]
        end else if (tick) begin
            s_d.flt = s_q.flt + 16'h0001;
        end
        if (rise_flt) begin
            if (s_q.fcnt != s_q.flim) begin
                s_d.fcnt = s_q.fcnt + 4'h1;
            end else if (s_q.flim != 4'h0) begin
                go_hard = 1'b1; // [R8]
            end
        end
        if (wd_fail && (s_q.wcnt != s_q.wlim)) begin
            s_d.wcnt = s_q.wcnt + 4'h1;
        end
        if ((s_q.wlim != 4'h0) && (s_q.wcnt == s_q.wlim)) begin
            go_hard = 1'b1; // [R9]
        end
        if (rise_tsd) begin
            go_hard = 1'b1; // [R10]
        end

        // Register writes
        if (bus.wr) begin
            if (bus.addr == `PDS_OFF_CTRL) begin
                if (bus.wdata[`PDS_C_SWOFF]) begin
                    s_d.swoff = 1'b1;
                    s_d.pend = 1'b1; // [R3]
                    s_d.swt = 10'h000;
                end
                s_d.pdmode = bus.wdata[`PDS_C_PDMODE];
                s_d.ovlo_en = bus.wdata[`PDS_C_OVEN];
                s_d.ovlo_sd = bus.wdata[`PDS_C_OVSD];
                s_d.pgpo = bus.wdata[`PDS_C_PGPO];
                s_d.imask = bus.wdata[`PDS_C_IMASK];
                s_d.btn_mode = bus.wdata[`PDS_C_BTN];
                s_d.tbase = bus.wdata[`PDS_C_TB +: 2];
                s_d.lead = bus.wdata[`PDS_C_LEAD +: 2];
                s_d.flim = bus.wdata[`PDS_C_FLIM +: 4];
                s_d.wlim = bus.wdata[`PDS_C_WLIM +: 4];
            end
            if (bus.addr == `PDS_OFF_STAT) begin
                if (bus.wdata[`PDS_S_PEND]) begin
                    s_d.pend = 1'b0; // [R4]
                    s_d.swoff = 1'b0; // [R5]
                    s_d.swt = 10'h000;
                end
                if (bus.wdata[`PDS_S_SBDONE]) begin
                    s_d.sbdone = 1'b0;
                end
                if (bus.wdata[`PDS_S_HARD]) begin
                    s_d.hardf = 1'b0;
                end
            end
            if (bus.addr == `PDS_OFF_FCNT) begin
                s_d.fcnt = bus.wdata[3:0];
                s_d.wcnt = bus.wdata[7:4];
            end
            if (bus.addr == `PDS_OFF_GDLY) begin
                s_d.gdly = bus.wdata[7:0];
            end
            if (bus.addr == `PDS_OFF_STBY) begin
                s_d.stby = bus.wdata[`PDS_NOUT-1:0];
            end
            if (sh) begin
                s_d.slot[si] = bus.wdata[7:0];
                s_d.grp[si] = bus.wdata[9:8];
            end
        end

        // Hardware sets come after the clears, so a set in the clearing cycle wins
        if (go_hard && live) begin
            s_d.hardf = 1'b1;
        end

        case (s_q.st)
            PDS_OFF: begin
                s_d.on = '0;
                s_d.swoff = 1'b0;
                s_d.swt = 10'h000;
                s_d.tbase = otp.stored_slot_timebase; // [R17]
                s_d.slot = otp.stored_slot; // [R17]
                if (pwrup_go) begin
                    s_d.st = PDS_RUN;
                    for (int i = 0; i < `PDS_NOUT; i++) begin
                        s_d.on[i] = otp.stored_slot[i] != 8'h00;
                    end
                    s_d.on[`PDS_RST] = 1'b1;
                end
            end
            PDS_RUN, PDS_STBY: begin
                if (go_hard) begin
                    start = 1'b1;
                    tnew = s_q.on;
                    wnew = `PDS_WHY_HARD;
                end else if (go_off) begin
                    start = 1'b1;
                    tnew = s_q.on;
                end else if ((s_q.st == PDS_RUN) && standby_req) begin
                    if ((s_q.on & s_q.stby) == '0) begin
                        s_d.st = PDS_STBY; // [R13]
                        s_d.tgt = '0;
                        s_d.sbdone = 1'b1; // [R14]
                    end else begin
                        start = 1'b1; // [R13]
                        tnew = s_q.on & s_q.stby;
                        wnew = `PDS_WHY_STBY;
                    end
                end else if ((s_q.st == PDS_STBY) && !standby_req) begin
                    s_d.st = PDS_RUN;
                    s_d.on = s_q.on | s_q.tgt;
                end
            end
            PDS_PD: begin
                if (s_q.tmr != 11'h000) begin
                    if (tick) begin
                        s_d.tmr = s_q.tmr - 11'h001;
                    end
                end else if (!s_q.pdmode) begin
                    // Empty slots take one cycle each, not a timebase
                    s_d.on = s_q.on & ~hit; // [R15] [R16]
                    if (s_q.cur == 8'h00) begin
                        s_d.ph = 2'h3;
                    end else begin
                        s_d.cur = s_q.cur - 8'h01;
                        if (hit != '0) begin
                            s_d.tmr = pick(s_q.tbase, `PDS_TB_US); // [R15] [R23]
                        end
                    end
                end else begin
                    case (s_q.ph)
                        2'h0: begin
                            if (mem == '0) begin
                                s_d.ph = 2'h2; // [R19]
                            end else if (mem[`PDS_RST] && s_q.on[`PDS_RST] && (s_q.lead != 2'h0)) begin
                                s_d.on[`PDS_RST] = 1'b0; // [R21]
                                s_d.tmr = pick(s_q.lead, `PDS_LEAD_US);
                                s_d.ph = 2'h1;
                            end else begin
                                s_d.on = s_q.on & ~mem; // [R18] [R21]
                                s_d.tmr = pick(s_q.gdly[s_q.gi], `PDS_GAP_US); // [R20]
                                s_d.ph = 2'h2;
                            end
                        end
                        2'h1: begin
                            s_d.on = s_q.on & ~mem; // [R21]
                            s_d.tmr = pick(s_q.gdly[s_q.gi], `PDS_GAP_US); // [R20]
                            s_d.ph = 2'h2;
                        end
                        2'h2: begin
                            s_d.ph = (s_q.gi == 2'h3) ? 2'h3 : 2'h0;
                            s_d.gi = s_q.gi + 2'h1; // [R19]
                        end
                        default: begin
                            s_d.ph = 2'h3;
                        end
                    endcase
                end
                if ((s_q.ph == 2'h3) && (s_q.tmr == 11'h000)) begin
                    case (s_q.why)
                        `PDS_WHY_HARD: s_d.st = PDS_FAILSAFE; // [R11]
                        `PDS_WHY_STBY: begin
                            s_d.st = PDS_STBY;
                            s_d.sbdone = 1'b1; // [R14]
                        end
                        default: s_d.st = PDS_OFF;
                    endcase
                end
            end
            PDS_FAILSAFE: begin
                s_d.st = PDS_OFF;
            end
            default: begin
                s_d.st = PDS_OFF;
            end
        endcase

        if (start) begin
            // Indicator-mode power-good is not sequenced
            tnew[`PDS_PG] = tnew[`PDS_PG] & s_q.pgpo; // [R22]
            s_d.st = PDS_PD;
            s_d.why = wnew;
            s_d.tgt = tnew;
            s_d.cur = 8'hff;
            s_d.gi = 2'h0; // [R19]
            s_d.ph = 2'h0;
            s_d.tmr = 11'h000;
            if (!s_q.pdmode) begin
                s_d.on = s_q.on & ~(tnew & slot0); // [R12] [R15]
            end
        end

        s_d.rdata = 32'h0000_0000;
        if (bus.rd) begin
            if (bus.addr == `PDS_OFF_CTRL) begin
                s_d.rdata[`PDS_C_SWOFF] = s_q.swoff;
                s_d.rdata[`PDS_C_PDMODE] = s_q.pdmode;
                s_d.rdata[`PDS_C_OVEN] = s_q.ovlo_en;
                s_d.rdata[`PDS_C_OVSD] = s_q.ovlo_sd;
                s_d.rdata[`PDS_C_PGPO] = s_q.pgpo;
                s_d.rdata[`PDS_C_IMASK] = s_q.imask;
                s_d.rdata[`PDS_C_BTN] = s_q.btn_mode;
                s_d.rdata[`PDS_C_TB +: 2] = s_q.tbase;
                s_d.rdata[`PDS_C_LEAD +: 2] = s_q.lead;
                s_d.rdata[`PDS_C_FLIM +: 4] = s_q.flim;
                s_d.rdata[`PDS_C_WLIM +: 4] = s_q.wlim;
            end else if (bus.addr == `PDS_OFF_STAT) begin
                s_d.rdata[`PDS_S_PEND] = s_q.pend;
                s_d.rdata[`PDS_S_SBDONE] = s_q.sbdone;
                s_d.rdata[`PDS_S_HARD] = s_q.hardf;
                s_d.rdata[`PDS_S_ST +: 3] = s_q.st;
                s_d.rdata[`PDS_S_ON +: `PDS_NOUT] = s_q.on;
            end else if (bus.addr == `PDS_OFF_FCNT) begin
                s_d.rdata[7:0] = {s_q.wcnt, s_q.fcnt};
            end else if (bus.addr == `PDS_OFF_GDLY) begin
                s_d.rdata[7:0] = s_q.gdly;
            end else if (bus.addr == `PDS_OFF_STBY) begin
                s_d.rdata[`PDS_NOUT-1:0] = s_q.stby;
            end else if (sh) begin
                s_d.rdata[9:0] = {s_q.grp[si], s_q.slot[si]};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign bus_rdata = s_q.rdata;
    assign reg_enable = s_q.on[6:0];
    assign host_reset_out_n = s_q.on[`PDS_RST];
    assign power_good_pin = s_q.pgpo ? s_q.on[`PDS_PG] : (s_q.st == PDS_RUN);
    assign interrupt_out_n = ~(s_q.pend & ~s_q.imask); // [R3]
    assign failsafe = s_q.st == PDS_FAILSAFE;

    a_pend_irq: assert property (@(posedge mclk) disable iff (rst) // [R3]
        (s_q.pend && !s_q.imask) |-> !interrupt_out_n) else $error("pending flag not on interrupt");
    a_swoff_write: assert property (@(posedge mclk) disable iff (rst) // [R3]
        (ce && bus.wr && bus.addr == `PDS_OFF_CTRL && bus.wdata[0]) |=> (s_q.pend && s_q.swt == 10'h000))
        else $error("software off did not raise pending");
    a_swoff_clear: assert property (@(posedge mclk) disable iff (rst) // [R5]
        !s_q.pend |-> !s_q.swoff) else $error("software off stuck after clear");
    a_btn_low: assert property (@(posedge mclk) disable iff (rst) // [R1]
        (ce && s_q.st == PDS_RUN && !s_q.btn_mode && !s_q.pin_s2.power_on_pin) |=> s_q.st != PDS_RUN)
        else $error("pin low did not start power down");
    a_ovlo_off: assert property (@(posedge mclk) disable iff (rst) // [R6]
        (ce && s_q.st == PDS_RUN && s_q.ovlo_en && s_q.ovlo_sd && s_q.pin_s2.input_overvoltage_event)
        |=> s_q.st == PDS_PD) else $error("overvoltage ignored");
    a_tsd_hard: assert property (@(posedge mclk) disable iff (rst) // [R10]
        (ce && live && rise_tsd) |=> (s_q.hardf && s_q.why == `PDS_WHY_HARD)) else $error("thermal not hard");
    a_hard_fsafe: assert property (@(posedge mclk) disable iff (rst) // [R11]
        ($past(s_q.st) == PDS_PD && $past(s_q.why) == `PDS_WHY_HARD && s_q.st != PDS_PD)
        |-> s_q.st == PDS_FAILSAFE) else $error("hard fault skipped fail-safe");
    a_stby_done: assert property (@(posedge mclk) disable iff (rst) // [R14]
        (s_q.st == PDS_STBY && $past(s_q.st) != PDS_STBY) |-> s_q.sbdone) else $error("standby done missing");
    a_slot0_off: assert property (@(posedge mclk) disable iff (rst) // [R15]
        (s_q.st == PDS_PD && !s_q.pdmode) |-> (s_q.on & s_q.tgt & slot0) == '0) else $error("slot zero still on");
    a_lead_rst: assert property (@(posedge mclk) disable iff (rst) // [R21]
        (s_q.st == PDS_PD && s_q.pdmode && s_q.ph == 2'h1) |-> (!host_reset_out_n && mem[`PDS_RST]))
        else $error("lead delay order wrong");
    a_reload: assert property (@(posedge mclk) disable iff (rst) // [R17]
        ($past(s_q.st) == PDS_OFF && $past(ce)) |-> s_q.tbase == $past(otp.stored_slot_timebase))
        else $error("timebase not reloaded");
endmodule // pds_sequencer
`default_nettype wire

// >>> testbench/pds_host_model.sv
// Host model: register bus master, pin drivers and stored configuration
`timescale 1ns/1ns
`default_nettype none
module pds_host_model (
    // Clock
    input wire logic mclk,
    // Register port
    output pds_pkg::pds_bus_t bus,
    input wire logic [31:0] bus_rdata,
    // Pins and stored values
    output pds_pkg::pds_pins_t pins,
    output pds_pkg::pds_otp_t otp
);
    import pds_pkg::*;
    initial begin
        bus = '0;
        pins = '0;
        otp = '0;
        // Output 2 before output 1 on the way up, so the reverse is checkable
        otp.stored_slot[1] = 8'h02;
        otp.stored_slot[2] = 8'h01;
        // Power-good sits above both, so as an output it drops first
        otp.stored_slot[7] = 8'h03;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 v = bus_rdata;
    endtask
    task automatic drive(input pds_pins_t p);
        @(posedge mclk);
        pins <= p;
    endtask
endmodule // pds_host_model
`default_nettype wire

// >>> testbench/power_down_sequencer_bench.sv
// Bench of the power-down sequencer
`timescale 1ns/1ns
`default_nettype none
module power_down_sequencer_bench;
    import pds_pkg::*;
    logic mclk, rst, ce, pwrup_go, standby_req, wd_fail, was_on;
    pds_bus_t bus;
    logic [31:0] bus_rdata, d;
    pds_pins_t pins;
    pds_otp_t otp;
    logic [6:0] reg_enable;
    logic power_good_pin, host_reset_out_n, interrupt_out_n, failsafe;
    int fail_count = 0;
    int checked = 0;
    int fs_cnt = 0;
    int n;
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (failsafe === 1'b1) fs_cnt <= fs_cnt + 1;
    pds_sequencer #(.OFF_HOLD_US(5), .FAULT_US(5)) u_pds_sequencer (.mclk(mclk), .rst(rst), .ce(ce), .bus(bus),
        .bus_rdata(bus_rdata), .pins(pins), .pwrup_go(pwrup_go), .standby_req(standby_req), .wd_fail(wd_fail),
        .otp(otp), .reg_enable(reg_enable), .power_good_pin(power_good_pin), .host_reset_out_n(host_reset_out_n),
        .interrupt_out_n(interrupt_out_n), .failsafe(failsafe));
    pds_host_model u_pds_host_model (.mclk(mclk), .bus(bus), .bus_rdata(bus_rdata), .pins(pins), .otp(otp));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        u_pds_host_model.wr(a, v);
    endtask
    task automatic rd(input logic [7:0] a);
        u_pds_host_model.rd(a, d);
    endtask
    task automatic pin(input pds_pins_t p);
        u_pds_host_model.drive(p);
    endtask
    // Polls the state field; n counts the cycles spent
    task automatic wait_st(input logic [2:0] e, input int lim);
        n = 0;
        do begin
            rd(8'h04);
            n += 2;
        end while (d[6:4] !== e && n < lim);
        chk("state", {29'h0, e}, {29'h0, d[6:4]});
    endtask
    task automatic up;
        @(posedge mclk);
        pwrup_go <= 1'b1;
        @(posedge mclk);
        pwrup_go <= 1'b0;
        wait_st(3'h1, 40);
    endtask
    task automatic pulse_wd;
        @(posedge mclk);
        wd_fail <= 1'b1;
        @(posedge mclk);
        wd_fail <= 1'b0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        fail_count++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        pwrup_go = 1'b0;
        standby_req = 1'b0;
        wd_fail = 1'b0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk("enables", 32'h0, {25'h0, reg_enable});
        chk("host reset", 32'h0, {31'h0, host_reset_out_n});
        chk("interrupt", 32'h1, {31'h0, interrupt_out_n});
        wait_st(3'h0, 4);
        $display("test reset done");
        pin(4'h8);
        up();
        wr(8'h1c, 32'h5);
        wr(8'h00, 32'h1);
        rd(8'h04);
        chk("pending", 32'h1, {31'h0, d[0]});
        chk("interrupt", 32'h0, {31'h0, interrupt_out_n});
        // Half the timer runs first, so a timer left running would fire early
        repeat (12500) @(posedge mclk);
        wr(8'h04, 32'h1);
        rd(8'h00);
        chk("off request", 32'h0, {31'h0, d[0]});
        wr(8'h00, 32'h11);
        wait_st(3'h3, 27000);
        chk("timer", 32'h1, {31'h0, n >= 24800});
        chk("slot zero", 32'h0, {31'h0, reg_enable[0]});
        chk("slot zero reset", 32'h0, {31'h0, host_reset_out_n});
        chk("later slots on", 32'h3, {30'h0, reg_enable[2:1]});
        chk("power good", 32'h1, {31'h0, power_good_pin});
        for (int i = 0; i < 5000; i++) begin
            @(posedge mclk);
            if (reg_enable[2:1] === 2'b01) chk("reverse order", 32'h0, 32'h1);
            if (power_good_pin === 1'b1 && reg_enable[1] === 1'b0) chk("power good slot", 32'h0, 32'h1);
        end
        wait_st(3'h0, 6000);
        chk("enables off", 32'h0, {25'h0, reg_enable});
        for (int i = 0; i < 4; i++) begin
            rd(8'h10 + 8'(4 * i));
            chk("slot", {24'h0, otp.stored_slot[i]}, {24'h0, d[7:0]});
        end
        $display("test software off done");
        up();
        @(posedge mclk);
        standby_req <= 1'b1;
        wait_st(3'h2, 4);
        chk("standby done", 32'h1, {31'h0, d[1]});
        @(posedge mclk);
        standby_req <= 1'b0;
        wait_st(3'h1, 4);
        pin(4'h0);
        wait_st(3'h3, 12);
        wait_st(3'h0, 6000);
        pin(4'h8);
        up();
        wr(8'h00, 32'h40);
        pin(4'h0);
        repeat (100) @(posedge mclk);
        pin(4'h8);
        wait_st(3'h1, 4);
        pin(4'h0);
        wait_st(3'h3, 1000);
        chk("hold", 32'h1, {31'h0, n >= 200});
        wait_st(3'h0, 6000);
        $display("test power-on pin done");
        pin(4'h8);
        up();
        wr(8'h00, 32'h4);
        pin(4'hc);
        repeat (20) @(posedge mclk);
        wait_st(3'h1, 4);
        wr(8'h00, 32'hc);
        wait_st(3'h3, 12);
        wait_st(3'h0, 6000);
        pin(4'h8);
        up();
        wr(8'h00, 32'h20000);
        pulse_wd();
        wait_st(3'h1, 4);
        pulse_wd();
        wait_st(3'h3, 12);
        wait_st(3'h0, 6000);
        chk("hard flag", 32'h1, {31'h0, d[2]});
        chk("fail-safe", 32'h1, 32'(fs_cnt));
        $display("test overvoltage and watchdog done");
        wr(8'h04, 32'h4);
        // The watchdog count still equals its limit and would stop the next power-up
        wr(8'h08, 32'h0);
        up();
        wr(8'h0c, 32'h0);
        wr(8'h14, 32'h302);
        wr(8'h2c, 32'h303);
        wr(8'h00, 32'h402);
        was_on = reg_enable[1];
        pin(4'ha);
        wait_st(3'h3, 12);
        chk("reset first", 32'h2, {30'h0, reg_enable[2], host_reset_out_n});
        repeat (600) @(posedge mclk);
        chk("group 4", 32'h0, {30'h0, reg_enable[2], reg_enable[0]});
        chk("group 1 held", {31'h0, was_on}, {31'h0, reg_enable[1]});
        wait_st(3'h0, 30000);
        chk("gap", 32'h1, {31'h0, n >= 11500});
        chk("hard flag", 32'h1, {31'h0, d[2]});
        chk("fail-safe", 32'h2, 32'(fs_cnt));
        $display("test group thermal done");
        complete_run();
    end
endmodule // power_down_sequencer_bench
`default_nettype wire
